// [rtl/tlvic_ctrl.sv]
/*
 * two-level vectored interrupt controller with wishbone register port.
 * assumes: one clock, request strobes and core handshakes come from logic
 * on the same clock; the core pulses irqAck when it takes the vector and
 * retiPulse when a service routine returns.
 */
`timescale 1ns/1ps
`include "tlvic_cfg.svh"
module tlvic_ctrl (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        arst_n,
  // wishbone slave
  input  wire logic                        cyc_i,
  input  wire logic                        stb_i,
  input  wire logic                        we_i,
  input  wire logic [11:0]                 adr_i,
  input  wire logic [3:0]                  sel_i,
  input  wire logic [31:0]                 dat_i,
  output logic      [31:0]                 dat_o,
  output logic                             ack_o,
  // peripheral requests
  input  wire tlvic_pkg::tlvic_periph_req_t periphReq,
  input  wire logic                        wdTimeout,
  // core handshake
  output tlvic_pkg::tlvic_core_req_t        coreReq,
  input  wire logic                        irqAck,
  input  wire logic                        retiPulse,
  // side outputs
  output logic                             wdResetReq,
  output logic                             irqOut
);
  import tlvic_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]  primEnReg;
  logic [7:0]  primPrioReg;
  logic [7:0]  secEpReg;
  logic [7:0]  wdCtrlReg;
  logic [10:0] pendReg;
  logic [10:0] pendNext;
  logic [10:0] maskReg;
  logic        actHighReg;
  logic        actLowReg;
  logic        ackReg;
  logic [31:0] datReg;
  logic        reqReg;
  logic        reqHighReg;
  logic [15:0] vecReg;
  logic [3:0]  srcReg;
  logic        wdResetReg;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire         busReq   = cyc_i & stb_i & ~ackReg;
  wire [7:0]   regIdx   = adr_i[9:2];
  wire         inRange  = (adr_i[11:10] == 2'h0);
  wire         busWr    = busReq & we_i & inRange;
  wire         lane0    = sel_i[0];
  wire         lane1    = sel_i[1];
  wire         wrPrimEn = busWr & lane0 &
                          (regIdx == `TLVIC_IDX_PRIMARY_ENABLE);
  wire         wrPrimPr = busWr & lane0 &
                          (regIdx == `TLVIC_IDX_PRIMARY_PRIO);
  wire         wrSecEp  = busWr & lane0 &
                          (regIdx == `TLVIC_IDX_SECONDARY_EP);
  wire         wrWdCtrl = busWr & lane0 &
                          (regIdx == `TLVIC_IDX_WD_CTRL);
  wire         wrStatus = busWr & (regIdx == `TLVIC_IDX_STATUS);
  wire         wrMask   = busWr & (regIdx == `TLVIC_IDX_MASK);
  wire [10:0]  laneMask = {{3{lane1}}, {8{lane0}}};

  // ****************************************************************
  // per-source enable and level
  // ****************************************************************
  wire [3:0]   wdTimeoutSet = wdCtrlReg[`TLVIC_WD_TIMEOUT_MSB:0];
  wire         wdSelect     = wdCtrlReg[`TLVIC_BIT_WD_SELECT];
  // a zero setting leaves the watchdog silent in both modes
  wire         wdArmed      = (wdTimeoutSet != 4'h0);
  wire         wdIrqEvt     = wdTimeout & wdArmed & wdSelect;
  wire         globalEn     = primEnReg[`TLVIC_BIT_GLOBAL_EN];

  wire [10:0]  srcEn;
  wire [10:0]  srcHigh;
  wire [10:0]  srcSet;

  assign srcEn[SRC_SUPPLY]   = secEpReg[`TLVIC_BIT_EN_SUPPLY];
  assign srcEn[SRC_WATCHDOG] = wdSelect & wdArmed;
  assign srcEn[SRC_EXT0]     = primEnReg[`TLVIC_BIT_EXT0];
  assign srcEn[SRC_CONV]     = primEnReg[`TLVIC_BIT_CONV];
  assign srcEn[SRC_TIMER0]   = primEnReg[`TLVIC_BIT_TIMER0];
  assign srcEn[SRC_EXT1]     = primEnReg[`TLVIC_BIT_EXT1];
  assign srcEn[SRC_TIMER1]   = primEnReg[`TLVIC_BIT_TIMER1];
  assign srcEn[SRC_TWOWIRE]  = secEpReg[`TLVIC_BIT_EN_TWOWIRE];
  assign srcEn[SRC_SERIAL]   = primEnReg[`TLVIC_BIT_SERIAL];
  assign srcEn[SRC_TIMER2]   = primEnReg[`TLVIC_BIT_TIMER2];
  assign srcEn[SRC_INTERVAL] = secEpReg[`TLVIC_BIT_EN_INTERVAL];

  // a set priority bit means the high level
  assign srcHigh[SRC_SUPPLY]   = secEpReg[`TLVIC_BIT_PRIO_SUPPLY];
  assign srcHigh[SRC_WATCHDOG] = 1'b1;
  assign srcHigh[SRC_EXT0]     = primPrioReg[`TLVIC_BIT_EXT0];
  assign srcHigh[SRC_CONV]     = primPrioReg[`TLVIC_BIT_CONV];
  assign srcHigh[SRC_TIMER0]   = primPrioReg[`TLVIC_BIT_TIMER0];
  assign srcHigh[SRC_EXT1]     = primPrioReg[`TLVIC_BIT_EXT1];
  assign srcHigh[SRC_TIMER1]   = primPrioReg[`TLVIC_BIT_TIMER1];
  assign srcHigh[SRC_TWOWIRE]  = secEpReg[`TLVIC_BIT_PRIO_TWOWIRE];
  assign srcHigh[SRC_SERIAL]   = primPrioReg[`TLVIC_BIT_SERIAL];
  assign srcHigh[SRC_TIMER2]   = primPrioReg[`TLVIC_BIT_TIMER2];
  assign srcHigh[SRC_INTERVAL] = secEpReg[`TLVIC_BIT_PRIO_INTERVAL];

  // combined flags fold into one source each
  assign srcSet[SRC_SUPPLY]   = periphReq.supplyMonitorReq;
  assign srcSet[SRC_WATCHDOG] = wdIrqEvt;
  assign srcSet[SRC_EXT0]     = periphReq.ext0Req;
  assign srcSet[SRC_CONV]     = periphReq.converterReadyReq;
  assign srcSet[SRC_TIMER0]   = periphReq.timer0OverflowReq;
  assign srcSet[SRC_EXT1]     = periphReq.ext1Req;
  assign srcSet[SRC_TIMER1]   = periphReq.timer1OverflowReq;
  assign srcSet[SRC_TWOWIRE]  = periphReq.twowirePortReq |
                                periphReq.fourwirePortReq;
  assign srcSet[SRC_SERIAL]   = periphReq.serialRxReq |
                                periphReq.serialTxReq;
  assign srcSet[SRC_TIMER2]   = periphReq.timer2OverflowReq |
                                periphReq.timer2ExternalReq;
  assign srcSet[SRC_INTERVAL] = periphReq.intervalCounterReq;

  // ****************************************************************
  // arbitration
  // ****************************************************************
  // the watchdog bypasses the global enable
  wire [10:0]  globalGate = {11{globalEn}} | (11'h001 << SRC_WATCHDOG);
  wire [10:0]  eligible   = pendReg & srcEn & globalGate;
  wire [10:0]  candHigh   = eligible & srcHigh;
  wire [10:0]  candLow    = eligible & ~srcHigh;

  wire         highValid;
  wire [3:0]   highIdx;
  wire         lowValid;
  wire [3:0]   lowIdx;

  tlvic_pick u_pickHigh (
    .cand  (candHigh),
    .valid (highValid),
    .idx   (highIdx)
  );

  tlvic_pick u_pickLow (
    .cand  (candLow),
    .valid (lowValid),
    .idx   (lowIdx)
  );

  // high waits only on a running high routine, low on either
  wire         grantHigh = highValid & ~actHighReg;
  // any high request is served ahead of low
  wire         grantLow  = lowValid & ~highValid &
                           ~actHighReg & ~actLowReg;
  wire         grantAny  = grantHigh | grantLow;
  wire [3:0]   grantIdx  = grantHigh ? highIdx : lowIdx;

  logic [15:0] grantVec;
  always_comb begin
    case (tlvic_src_t'(grantIdx))
      SRC_EXT0:     grantVec = `TLVIC_VEC_EXT0;
      SRC_TIMER0:   grantVec = `TLVIC_VEC_TIMER0;
      SRC_EXT1:     grantVec = `TLVIC_VEC_EXT1;
      SRC_TIMER1:   grantVec = `TLVIC_VEC_TIMER1;
      SRC_SERIAL:   grantVec = `TLVIC_VEC_SERIAL;
      SRC_TIMER2:   grantVec = `TLVIC_VEC_TIMER2;
      SRC_CONV:     grantVec = `TLVIC_VEC_CONV;
      SRC_TWOWIRE:  grantVec = `TLVIC_VEC_TWOWIRE;
      SRC_SUPPLY:   grantVec = `TLVIC_VEC_SUPPLY;
      SRC_INTERVAL: grantVec = `TLVIC_VEC_INTERVAL;
      SRC_WATCHDOG: grantVec = `TLVIC_VEC_WATCHDOG;
      default:      grantVec = 16'h0000;
    endcase
  end

  // ****************************************************************
  // pending flags: hardware set wins over any clear
  // ****************************************************************
  wire         takeAck  = irqAck & reqReg;
  wire [10:0]  ackClr   = takeAck ? (11'h001 << srcReg) : 11'h000;
  wire [10:0]  swClr    = wrStatus ? (dat_i[10:0] & laneMask) : 11'h000;

  assign pendNext = (pendReg & ~ackClr & ~swClr) | srcSet;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pendReg <= `TLVIC_RST_SRC;
    end else begin
      pendReg <= pendNext;
    end
  end

  // ****************************************************************
  // core request, registered; dropped at the acknowledge edge
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reqReg     <= 1'b0;
      reqHighReg <= 1'b0;
      vecReg     <= 16'h0000;
      srcReg     <= 4'h0;
    end else if (takeAck) begin
      reqReg     <= 1'b0;
    end else begin
      reqReg     <= grantAny;
      reqHighReg <= grantHigh;
      vecReg     <= grantVec;
      srcReg     <= grantIdx;
    end
  end

  assign coreReq.req    = reqReg;
  assign coreReq.high   = reqHighReg;
  assign coreReq.vector = vecReg;

  // ****************************************************************
  // active-level record
  // ****************************************************************
  // a return ends the innermost routine, the high one if both run
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      actHighReg <= 1'b0;
      actLowReg  <= 1'b0;
    end else if (takeAck) begin
      actHighReg <= actHighReg | reqHighReg;
      actLowReg  <= actLowReg | ~reqHighReg;
    end else if (retiPulse) begin
      if (actHighReg) begin
        actHighReg <= 1'b0;
      end else begin
        actLowReg  <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // watchdog reset request when not routed to an interrupt
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdResetReg <= 1'b0;
    end else begin
      wdResetReg <= wdTimeout & wdArmed & ~wdSelect;
    end
  end

  assign wdResetReq = wdResetReg;

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      primEnReg   <= `TLVIC_RST_PRIMARY_ENABLE;
      primPrioReg <= `TLVIC_RST_PRIMARY_PRIO;
      secEpReg    <= `TLVIC_RST_SECONDARY_EP;
      wdCtrlReg   <= `TLVIC_RST_WD_CTRL;
      maskReg     <= `TLVIC_RST_SRC;
    end else begin
      if (wrPrimEn) begin
        primEnReg <= dat_i[7:0];
      end
      if (wrPrimPr) begin
        primPrioReg <= {1'b0, dat_i[6:0]};
      end
      // reserved bits hold their reset value
      if (wrSecEp) begin
        secEpReg <= {1'b1, dat_i[6:4], 1'b0, dat_i[2:0]};
      end
      if (wrWdCtrl) begin
        wdCtrlReg <= {dat_i[7], 3'h0, dat_i[3:0]};
      end
      if (wrMask) begin
        maskReg <= (maskReg & ~laneMask) | (dat_i[10:0] & laneMask);
      end
    end
  end

  // ****************************************************************
  // read mux and bus answer
  // ****************************************************************
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (inRange) begin
      case (regIdx)
        `TLVIC_IDX_PRIMARY_ENABLE: rdMux = {24'h0, primEnReg};
        `TLVIC_IDX_PRIMARY_PRIO:   rdMux = {24'h0, primPrioReg};
        `TLVIC_IDX_SECONDARY_EP:   rdMux = {24'h0, secEpReg};
        `TLVIC_IDX_WD_CTRL:        rdMux = {24'h0, wdCtrlReg};
        `TLVIC_IDX_STATUS:         rdMux = {21'h0, pendReg};
        `TLVIC_IDX_MASK:           rdMux = {21'h0, maskReg};
        `TLVIC_IDX_ACTIVE:         rdMux = {20'h0, srcReg, 5'h00,
                                            reqReg, actHighReg,
                                            actLowReg};
        default:                   rdMux = 32'h0000_0000;
      endcase
    end
  end

  // one wait state; unmapped addresses still answer, reading zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ackReg <= 1'b0;
      datReg <= 32'h0000_0000;
    end else begin
      ackReg <= busReq;
      if (busReq && !we_i) begin
        datReg <= rdMux;
      end
    end
  end

  assign ack_o = ackReg;
  assign dat_o = datReg;

  // ****************************************************************
  // summary interrupt line
  // ****************************************************************
  assign irqOut = |(pendReg & maskReg);

endmodule

// [pkg/tlvic_cfg.svh]
/*
 * offsets, field positions, reset values and vector addresses of the
 * two-level vectored interrupt controller.
 * assumes a 32-bit classic wishbone slave port; register byte address is
 * four times the register index.
 */
`ifndef TLVIC_CFG_SVH
`define TLVIC_CFG_SVH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define TLVIC_IDX_PRIMARY_ENABLE   8'hA8
`define TLVIC_IDX_SECONDARY_EP     8'hA9
`define TLVIC_IDX_PRIMARY_PRIO     8'hB8
`define TLVIC_IDX_STATUS           8'hC0
`define TLVIC_IDX_MASK             8'hC1
`define TLVIC_IDX_WD_CTRL          8'hC2
`define TLVIC_IDX_ACTIVE           8'hC3

// ****************************************************************
// reset values
// ****************************************************************
`define TLVIC_RST_PRIMARY_ENABLE   8'h00
`define TLVIC_RST_PRIMARY_PRIO     8'h00
`define TLVIC_RST_SECONDARY_EP     8'hA0
`define TLVIC_RST_WD_CTRL          8'h00
`define TLVIC_RST_SRC              11'h000

// ****************************************************************
// primary enable / priority fields
// ****************************************************************
`define TLVIC_BIT_GLOBAL_EN        7
`define TLVIC_BIT_CONV             6
`define TLVIC_BIT_TIMER2           5
`define TLVIC_BIT_SERIAL           4
`define TLVIC_BIT_TIMER1           3
`define TLVIC_BIT_EXT1             2
`define TLVIC_BIT_TIMER0           1
`define TLVIC_BIT_EXT0             0

// ****************************************************************
// secondary enable/priority fields
// ****************************************************************
`define TLVIC_BIT_SEC_RSVD_HI      7
`define TLVIC_BIT_PRIO_INTERVAL    6
`define TLVIC_BIT_PRIO_SUPPLY      5
`define TLVIC_BIT_PRIO_TWOWIRE     4
`define TLVIC_BIT_SEC_RSVD_LO      3
`define TLVIC_BIT_EN_INTERVAL      2
`define TLVIC_BIT_EN_SUPPLY        1
`define TLVIC_BIT_EN_TWOWIRE       0

// ****************************************************************
// watchdog control fields
// ****************************************************************
`define TLVIC_BIT_WD_SELECT        7
`define TLVIC_WD_TIMEOUT_MSB       3

// ****************************************************************
// vector addresses
// ****************************************************************
`define TLVIC_VEC_EXT0             16'h0003
`define TLVIC_VEC_TIMER0           16'h000B
`define TLVIC_VEC_EXT1             16'h0013
`define TLVIC_VEC_TIMER1           16'h001B
`define TLVIC_VEC_SERIAL           16'h0023
`define TLVIC_VEC_TIMER2           16'h002B
`define TLVIC_VEC_CONV             16'h0033
`define TLVIC_VEC_TWOWIRE          16'h003B
`define TLVIC_VEC_SUPPLY           16'h0043
`define TLVIC_VEC_INTERVAL         16'h0053
`define TLVIC_VEC_WATCHDOG         16'h005B

`endif

// [pkg/tlvic_pkg.sv]
/*
 * types shared by the interrupt controller and its picker.
 * assumes nothing beyond a systemverilog elaborator.
 */
package tlvic_pkg;

  // ****************************************************************
  // source numbering, in polling order (0 is polled first)
  // ****************************************************************
  typedef enum logic [3:0] {
    SRC_SUPPLY,
    SRC_WATCHDOG,
    SRC_EXT0,
    SRC_CONV,
    SRC_TIMER0,
    SRC_EXT1,
    SRC_TIMER1,
    SRC_TWOWIRE,
    SRC_SERIAL,
    SRC_TIMER2,
    SRC_INTERVAL
  } tlvic_src_t;

  localparam int unsigned TLVIC_NSRC = 11;

  // ****************************************************************
  // peripheral request strobes, one cycle each
  // ****************************************************************
  typedef struct packed {
    logic supplyMonitorReq;
    logic ext0Req;
    logic converterReadyReq;
    logic timer0OverflowReq;
    logic ext1Req;
    logic timer1OverflowReq;
    logic twowirePortReq;
    logic fourwirePortReq;
    logic serialRxReq;
    logic serialTxReq;
    logic timer2OverflowReq;
    logic timer2ExternalReq;
    logic intervalCounterReq;
  } tlvic_periph_req_t;

  // ****************************************************************
  // request towards the core
  // ****************************************************************
  typedef struct packed {
    logic        req;
    logic        high;
    logic [15:0] vector;
  } tlvic_core_req_t;

endpackage

// [rtl/tlvic_pick.sv]
/*
 * fixed-order picker: grants the lowest-numbered candidate.
 * assumes candidates are given in polling order, bit 0 first.
 */
`timescale 1ns/1ps
module tlvic_pick (
  // candidates
  input  wire logic [10:0] cand,
  // result
  output logic             valid,
  output logic [3:0]       idx
);
  import tlvic_pkg::*;

  logic [10:0] oneHot;

  // ****************************************************************
  // one-hot of the first candidate
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < 11; i = i + 1) begin : g_first
      if (i == 0) begin : g_top
        assign oneHot[i] = cand[i];
      end else begin : g_rest
        assign oneHot[i] = cand[i] & ~(|cand[i-1:0]);
      end
    end
  endgenerate

  assign valid = |cand;

  always_comb begin
    idx = 4'h0;
    for (int k = 0; k < 11; k++) begin
      if (oneHot[k]) begin
        idx = 4'(k);
      end
    end
  end

endmodule

// [verification/tlvic_ctrl_monitor.sv]
/* port checker for the interrupt controller.
   assumes one clock domain; attached by the bind at the foot. */
`timescale 1ns/1ps
`include "tlvic_cfg.svh"
module tlvic_ctrl_monitor
  import tlvic_pkg::*;
(
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       arst_n,
  // bus
  input wire logic                       cyc_i,
  input wire logic                       stb_i,
  input wire logic                       ack_o,
  // core side
  input wire tlvic_pkg::tlvic_core_req_t coreReq,
  input wire logic                       irqAck,
  input wire logic                       retiPulse,
  input wire logic                       wdResetReq
);
  logic lowAct_reg;
  logic highAct_reg;

  // mirror of the running levels, as the core sees them
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lowAct_reg  <= 1'b0;
      highAct_reg <= 1'b0;
    end else if (coreReq.req && irqAck) begin
      highAct_reg <= highAct_reg | coreReq.high;
      lowAct_reg  <= lowAct_reg | !coreReq.high;
    end else if (retiPulse) begin
      highAct_reg <= 1'b0;
      lowAct_reg  <= lowAct_reg & highAct_reg;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence wbTake;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence grantTake;
    coreReq.req && irqAck;
  endsequence

  bus_answer_a: assert property (wbTake |=> ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(stb_i))
    else $error("ack without request");
  grant_drop_a: assert property (grantTake |=> !coreReq.req)
    else $error("request stays after grant");
  req_hold_a: assert property (coreReq.req && !irqAck |=> coreReq.req)
    else $error("request withdrawn before ack");
  high_block_a: assert property (highAct_reg |-> !coreReq.req)
    else $error("request during high routine");
  low_preempt_a: assert property (lowAct_reg && coreReq.req |-> coreReq.high)
    else $error("low request during low routine");
  wd_high_a: assert property (coreReq.req &&
    coreReq.vector == `TLVIC_VEC_WATCHDOG |-> coreReq.high)
    else $error("watchdog request not high");
  wd_pulse_a: assert property (wdResetReq |=> !wdResetReq)
    else $error("reset request longer than one cycle");
  vec_form_a: assert property (coreReq.req |-> coreReq.vector[2:0] == 3'h3)
    else $error("malformed vector");
endmodule

bind tlvic_ctrl tlvic_ctrl_monitor u_tlvic_ctrl_monitor (
  .core_clk(core_clk), .arst_n(arst_n), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .coreReq(coreReq), .irqAck(irqAck),
  .retiPulse(retiPulse), .wdResetReq(wdResetReq));

// [verification/tlvic_core_model.sv]
/* behavioural core: acks requests after a set delay, stacks the pc.
   assumes the controller holds its request until the ack. */
`timescale 1ns/1ps
module tlvic_core_model
  import tlvic_pkg::*;
(
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       arst_n,
  // controller side
  input  wire tlvic_pkg::tlvic_core_req_t coreReq,
  output logic                            irqAck,
  output logic                            retiPulse,
  // bench side
  input  wire logic [3:0]                 ackDelay,
  input  wire logic                       retiCmd,
  output logic [7:0]                      takes,
  output logic                            lastHigh,
  output logic [15:0]                     pc
);
  logic [15:0] stack_reg [0:7];
  logic [2:0]  sp_reg;
  logic [3:0]  wait_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqAck    <= 1'b0;
      retiPulse <= 1'b0;
      takes     <= 8'h00;
      lastHigh  <= 1'b0;
      pc        <= 16'h0100;
      sp_reg    <= 3'h0;
      wait_reg  <= 4'h0;
    end else begin
      irqAck    <= 1'b0;
      retiPulse <= retiCmd;
      if (irqAck) begin
        stack_reg[sp_reg] <= pc;
        sp_reg            <= sp_reg + 3'h1;
        pc                <= coreReq.vector;
        lastHigh          <= coreReq.high;
        takes             <= takes + 8'h01;
      end else if (coreReq.req) begin
        irqAck   <= (wait_reg == ackDelay);
        wait_reg <= (wait_reg == ackDelay) ? 4'h0 : wait_reg + 4'h1;
      end else if (retiCmd) begin
        sp_reg <= sp_reg - 3'h1;
        pc     <= stack_reg[sp_reg - 3'h1];
      end
    end
  end
endmodule

// [verification/tlvic_ctrl_test.sv]
/* register and vector tests of the interrupt controller.
   assumes the core model and the bound port checker. */
`timescale 1ns/1ps
module tlvic_ctrl_test;
  import tlvic_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic wdTo = 1'b0, retiCmd = 1'b0, ack, irqAck, retiPulse, wdRst, irqOut;
  logic [11:0] adr = 12'h000;
  logic [31:0] datW = 32'h0, datR;
  logic [3:0] ackDelay = 4'h0;
  logic [7:0] takes, seen = 8'h00;
  logic [15:0] pc;
  logic lastHigh;
  tlvic_periph_req_t periph = '0;
  tlvic_core_req_t coreReq;
  int nFail = 0, totalChecks = 0, nWd = 0;
  logic [7:0] rIdx [0:7] = '{8'hA8, 8'hA9, 8'hB8, 8'hC0, 8'hC1, 8'hC2,
    8'hC3, 8'h55};
  logic [15:0] pollVec [0:9] = '{16'h0043, 16'h0003, 16'h0033, 16'h000B,
    16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
  logic [12:0] soloReq [0:2] = '{13'h0020, 13'h0008, 13'h0002};
  logic [15:0] soloVec [0:2] = '{16'h003B, 16'h0023, 16'h002B};

  tlvic_ctrl u_tlvic_ctrl (.core_clk(core_clk), .arst_n(arst_n),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
    .dat_i(datW), .dat_o(datR), .ack_o(ack), .periphReq(periph),
    .wdTimeout(wdTo), .coreReq(coreReq), .irqAck(irqAck),
    .retiPulse(retiPulse), .wdResetReq(wdRst), .irqOut(irqOut));
  tlvic_core_model u_tlvic_core_model (.core_clk(core_clk),
    .arst_n(arst_n), .coreReq(coreReq), .irqAck(irqAck),
    .retiPulse(retiPulse), .ackDelay(ackDelay), .retiCmd(retiCmd),
    .takes(takes), .lastHigh(lastHigh), .pc(pc));
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (wdRst === 1'b1) nWd++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] d, output logic [31:0] r);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {2'b00, idx, 2'b00};
    datW <= d;
    @(posedge core_clk);
    while (ack !== 1'b1) @(posedge core_clk);
    r = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic pulse(input logic [12:0] m);
    periph <= tlvic_periph_req_t'(m);
    @(posedge core_clk);
    periph <= '0;
    @(posedge core_clk);
  endtask
  task automatic wdp;
    wdTo <= 1'b1;
    @(posedge core_clk);
    wdTo <= 1'b0;
    @(posedge core_clk);
  endtask
  // waits for the core to take a vector, then compares where it jumped
  task automatic take(input logic [15:0] v, input logic h);
    int n;
    n = 0;
    while (takes === seen && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    seen = takes;
    chk(32'(pc), (n < 40) ? 32'(v) : 32'h0001_0000);
    chk(32'(lastHigh), 32'(h));
  endtask
  task automatic none;
    repeat (12) @(posedge core_clk);
    chk(32'(takes), 32'(seen));
  endtask
  task automatic reti;
    retiCmd <= 1'b1;
    @(posedge core_clk);
    retiCmd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic testDone;
    if (nFail == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) rdc(rIdx[i], (i == 1) ? 32'hA0 : 32'h0);
    wr(8'hB8, 32'hFF);
    rdc(8'hB8, 32'h7F);
    wr(8'hB8, 32'h00);
    // ****************************************************************
    // sticky flag, mask and interrupt line
    // ****************************************************************
    wr(8'hC1, 32'h004);
    pulse(13'h0800);
    chk(32'(irqOut), 32'h1);
    rdc(8'hC0, 32'h004);
    wr(8'hC1, 32'h000);
    chk(32'(irqOut), 32'h0);
    wr(8'hC1, 32'h004);
    wr(8'hC0, 32'h004);
    chk(32'(irqOut), 32'h0);
    none();
    // ****************************************************************
    // polling order with a slow core, then shared flags
    // ****************************************************************
    ackDelay <= 4'h2;
    wr(8'hA8, 32'hFF);
    wr(8'hA9, 32'h07);
    pulse(13'h1FFF);
    for (int i = 0; i < 10; i++) begin
      take(pollVec[i], 1'b0);
      reti();
    end
    ackDelay <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      pulse(soloReq[i]);
      take(soloVec[i], 1'b0);
      reti();
    end
    // ****************************************************************
    // two levels: ordering, blocking, preemption
    // ****************************************************************
    wr(8'hB8, 32'h08);
    pulse(13'h0880);
    take(16'h001B, 1'b1);
    none();
    reti();
    take(16'h0003, 1'b0);
    pulse(13'h0200);
    none();
    pulse(13'h0080);
    take(16'h001B, 1'b1);
    reti();
    reti();
    take(16'h000B, 1'b0);
    reti();
    // ****************************************************************
    // watchdog against the global enable
    // ****************************************************************
    wr(8'hA8, 32'h01);
    pulse(13'h0800);
    none();
    wr(8'hC0, 32'h004);
    wr(8'hC2, 32'h80);
    wdp();
    none();
    wr(8'hC2, 32'h85);
    wdp();
    take(16'h005B, 1'b1);
    reti();
    wr(8'hC2, 32'h05);
    wdp();
    repeat (3) @(posedge core_clk);
    chk(32'(nWd), 32'h1);
    chk(32'(pc), 32'h0100);
    testDone();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    nFail++;
    testDone();
  end
endmodule
